/* File: logic/csd_pkg.sv */
// Notes on behaviour
// - An instruction word with upper byte 0110010a is the greater-than compare-and-skip, low byte the file address.
// - An instruction word with upper byte 0110000a is the less-than compare-and-skip, low byte the file address.
// - The greater-than compare subtracts W from the operand unsigned and skips the fetched next instruction when the operand is larger.
// - The less-than compare subtracts W from the operand unsigned and skips the fetched next instruction when the operand is smaller.
// - Access bit 0 addresses the access bank, access bit 1 forms the address from the bank select register.
// - Access bit 0 with the extended set enabled and address at most 95 uses indexed literal offset addressing.
// - A compare is one word and takes one cycle, two on a skip, three when the skipped instruction is two words.
// - A skip adds one idle cycle of four idle quarter-phases, two idle cycles for a two-word skipped instruction.
// - Decimal adjust adds 6 to the low nibble of W when it exceeds 9 or digit carry is set, else leaves it.
// - Decimal adjust adds 6 to the high nibble of W and sets carry when it exceeds 9 or carry is set, else leaves it.
// - Decimal adjust works on each nibble of W separately; a carry out of the low nibble adjust is not added into the high nibble.
package csd_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] INSTR_OFS = 5'h04;
  localparam logic [4:0] WORKING_OFS = 5'h08;
  localparam logic [4:0] BANK_OFS = 5'h0C;
  localparam logic [4:0] STATUS_OFS = 5'h10;
  localparam logic [4:0] OPERAND_OFS = 5'h14;
  localparam logic [4:0] INDEX_OFS = 5'h18;
  localparam logic [4:0] RESULT_OFS = 5'h1C;

  // ----------------------------------------------------------------
  // Fields and encodings
  // ----------------------------------------------------------------
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_TWO_WORD_BIT = 1;
  localparam logic [6:0] OPC_GREATER = 7'h32;
  localparam logic [6:0] OPC_LESS = 7'h30;
  localparam logic [15:0] OPC_DECIMAL_ADJUST = 16'h0007;
  localparam logic [7:0] INDEXED_MAX = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hF;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;
  localparam int PHASES = 4;
  localparam logic [1:0] LAST_PHASE = 2'(PHASES - 1);

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] WORKING_RST = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [11:0] INDEX_RST = 12'h000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_SKIP = 2'b10
  } csd_state_e;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } csd_status_s;

  typedef struct packed {
    logic unknown;
    logic busy;
    logic skipped;
    logic access_bank;
    logic indexed;
    logic [11:0] addr;
  } csd_result_s;

endpackage

/* File: logic/csd_core.sv */
`timescale 1ns/1ps
module csd_core (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Core view
  output logic busy,
  output logic [1:0] q_phase,
  output logic nop_substitute,
  output logic [11:0] mem_addr
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [8:0] decimal_adjust(input logic [7:0] w,
                                                input logic dc,
                                                input logic c);
    logic [3:0] lo;
    logic [3:0] hi;
    logic cy;
    lo = w[3:0];
    hi = w[7:4];
    cy = c;
    if (lo > csd_pkg::BCD_MAX || dc)
      lo = lo + csd_pkg::BCD_FIX;
    if (hi > csd_pkg::BCD_MAX || c)
    begin
      hi = hi + csd_pkg::BCD_FIX;
      cy = 1'b1;
    end
    return {cy, hi, lo};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  csd_pkg::csd_state_e state_q;
  logic [1:0] phase_q;
  logic [1:0] idle_left_q;
  logic ext_en_q;
  logic two_word_q;
  logic [15:0] instr_q;
  logic [7:0] working_q;
  logic [3:0] bank_q;
  csd_pkg::csd_status_s status_q;
  logic [7:0] operand_q;
  logic [11:0] index_q;
  csd_pkg::csd_result_s result_q;
  logic wait_q;
  logic [31:0] rdata_q;

  logic req;
  logic instr_wr_blocked;
  logic wr_en;
  logic start;
  logic is_gt;
  logic is_lt;
  logic is_daw;
  logic access_bit;
  logic [7:0] f_addr;
  logic take_skip;
  logic [8:0] daw_res;
  logic [11:0] ea;
  logic ea_indexed;
  logic exec_end;
  logic busy_d;

  assign req = avs_read | avs_write;
  // New instructions wait until the previous one, idle cycles included,
  // has retired; the stall shows as a held waitrequest.
  assign instr_wr_blocked = avs_write && avs_address == csd_pkg::INSTR_OFS
                            && state_q != csd_pkg::ST_IDLE;
  assign wr_en = avs_write && !wait_q;
  assign start = wr_en && avs_address == csd_pkg::INSTR_OFS;

  assign is_gt = instr_q[15:9] == csd_pkg::OPC_GREATER;
  assign is_lt = instr_q[15:9] == csd_pkg::OPC_LESS;
  assign is_daw = instr_q == csd_pkg::OPC_DECIMAL_ADJUST;
  assign access_bit = instr_q[8];
  assign f_addr = instr_q[7:0];
  assign daw_res = decimal_adjust(working_q, status_q.dc, status_q.c);
  assign exec_end = state_q == csd_pkg::ST_EXEC
                    && phase_q == csd_pkg::LAST_PHASE;

  // Unsigned compare; the difference itself is never stored
  assign take_skip = (is_gt && operand_q > working_q)
                     || (is_lt && operand_q < working_q);

  // Busy tracks the sequencer's next state, so it spans exactly the
  // instruction cycle and its idle cycles: 4, 8 or 12 clocks
  assign busy_d = start
                  || (state_q == csd_pkg::ST_EXEC && !exec_end)
                  || (exec_end && take_skip)
                  || (state_q == csd_pkg::ST_SKIP
                      && !(phase_q == csd_pkg::LAST_PHASE
                           && idle_left_q == 2'h1));

  // ----------------------------------------------------------------
  // Operand address formation
  // ----------------------------------------------------------------
  always_comb
  begin
    ea_indexed = 1'b0;
    if (access_bit)
      ea = {bank_q, f_addr};
    else if (ext_en_q && f_addr <= csd_pkg::INDEXED_MAX)
    begin
      ea = index_q + {4'h0, f_addr};
      ea_indexed = 1'b1;
    end
    else if (f_addr < csd_pkg::ACCESS_SPLIT)
      ea = {4'h0, f_addr};
    else
      ea = {csd_pkg::ACCESS_HIGH_PAGE, f_addr};
  end

  // ----------------------------------------------------------------
  // Instruction sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= csd_pkg::ST_IDLE;
      phase_q <= 2'h0;
      idle_left_q <= 2'h0;
    end
    else
    begin
      case (state_q)
        csd_pkg::ST_IDLE:
        begin
          phase_q <= 2'h0;
          if (start)
            state_q <= csd_pkg::ST_EXEC;
        end
        csd_pkg::ST_EXEC:
        begin
          phase_q <= phase_q + 2'h1;
          if (phase_q == csd_pkg::LAST_PHASE)
          begin
            if (take_skip)
            begin
              state_q <= csd_pkg::ST_SKIP;
              idle_left_q <= two_word_q ? 2'h2 : 2'h1;
            end
            else
              state_q <= csd_pkg::ST_IDLE;
          end
        end
        csd_pkg::ST_SKIP:
        begin
          phase_q <= phase_q + 2'h1;
          if (phase_q == csd_pkg::LAST_PHASE)
          begin
            idle_left_q <= idle_left_q - 2'h1;
            if (idle_left_q == 2'h1)
              state_q <= csd_pkg::ST_IDLE;
          end
        end
        default:
          state_q <= csd_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result capture
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      result_q <= '0;
    else
    begin
      result_q.busy <= busy_d;
      if (start)
      begin
        result_q.skipped <= 1'b0;
        result_q.unknown <= 1'b0;
      end
      else if (exec_end)
      begin
        result_q.skipped <= take_skip;
        result_q.unknown <= !(is_gt || is_lt || is_daw);
        if (is_gt || is_lt)
        begin
          result_q.addr <= ea;
          result_q.indexed <= ea_indexed;
          result_q.access_bank <= !access_bit;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Working register and status
  // ----------------------------------------------------------------
  // The adjust retires at the last phase and takes priority over a bus
  // write landing on the same edge.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      working_q <= csd_pkg::WORKING_RST;
    else if (exec_end && is_daw)
      working_q <= daw_res[7:0];
    else if (wr_en && avs_address == csd_pkg::WORKING_OFS)
      working_q <= avs_writedata[7:0];
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      status_q <= '0;
    else if (exec_end && is_daw)
      status_q.c <= daw_res[8];
    else if (wr_en && avs_address == csd_pkg::STATUS_OFS)
      status_q <= avs_writedata[4:0];
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_en_q <= 1'b0;
      two_word_q <= 1'b0;
      instr_q <= 16'h0000;
      bank_q <= csd_pkg::BANK_RST;
      operand_q <= 8'h00;
      index_q <= csd_pkg::INDEX_RST;
    end
    else if (wr_en)
    begin
      if (avs_address == csd_pkg::CTRL_OFS)
      begin
        ext_en_q <= avs_writedata[csd_pkg::CTRL_EXT_BIT];
        two_word_q <= avs_writedata[csd_pkg::CTRL_TWO_WORD_BIT];
      end
      else if (avs_address == csd_pkg::INSTR_OFS)
        instr_q <= avs_writedata[15:0];
      else if (avs_address == csd_pkg::BANK_OFS)
        bank_q <= avs_writedata[3:0];
      else if (avs_address == csd_pkg::OPERAND_OFS)
        operand_q <= avs_writedata[7:0];
      else if (avs_address == csd_pkg::INDEX_OFS)
        index_q <= avs_writedata[11:0];
    end
  end

  // ----------------------------------------------------------------
  // Bus handshake and read data
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      wait_q <= 1'b1;
    else
      wait_q <= !(req && wait_q && !instr_wr_blocked);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rdata_q <= 32'h0000_0000;
    else if (avs_read && wait_q)
    begin
      if (avs_address == csd_pkg::CTRL_OFS)
        rdata_q <= {30'h0, two_word_q, ext_en_q};
      else if (avs_address == csd_pkg::INSTR_OFS)
        rdata_q <= {16'h0000, instr_q};
      else if (avs_address == csd_pkg::WORKING_OFS)
        rdata_q <= {24'h000000, working_q};
      else if (avs_address == csd_pkg::BANK_OFS)
        rdata_q <= {28'h0000000, bank_q};
      else if (avs_address == csd_pkg::STATUS_OFS)
        rdata_q <= {27'h0000000, status_q};
      else if (avs_address == csd_pkg::OPERAND_OFS)
        rdata_q <= {24'h000000, operand_q};
      else if (avs_address == csd_pkg::INDEX_OFS)
        rdata_q <= {20'h00000, index_q};
      else if (avs_address == csd_pkg::RESULT_OFS)
        rdata_q <= {15'h0000, result_q};
      else
        rdata_q <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Core view outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      q_phase <= 2'h0;
      nop_substitute <= 1'b0;
      mem_addr <= 12'h000;
    end
    else
    begin
      q_phase <= phase_q;
      nop_substitute <= state_q == csd_pkg::ST_SKIP;
      if (state_q == csd_pkg::ST_EXEC)
        mem_addr <= ea;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign busy = result_q.busy;

endmodule

/* File: tb/csd_checker.sv */
`timescale 1ns/1ps
module csd_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Core view
  input wire logic busy,
  input wire logic [1:0] q_phase,
  input wire logic nop_substitute,
  input wire logic [11:0] mem_addr
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_wait_one_low: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_has_req: assert property
    (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
    else $error("answer without a request");
  a_busy_len: assert property ($rose(busy) |-> busy[*4] ##[1:9] !busy)
    else $error("instruction length out of range");
  a_skip_idle_run: assert property ($rose(nop_substitute) |->
    nop_substitute[*4] ##1 (!nop_substitute or
    nop_substitute[*4] ##1 !nop_substitute))
    else $error("idle cycle run is not four or eight clocks");
  a_nop_in_busy: assert property ($rose(nop_substitute) |-> $past(busy))
    else $error("no-op substitute outside an instruction");
  a_phase_walk: assert property (q_phase == 2'h1 |=>
    q_phase == 2'h2 ##1 q_phase == 2'h3)
    else $error("quarter phases out of order");
  a_addr_idle_hold: assert property
    (!busy && !$past(busy) |-> $stable(mem_addr))
    else $error("operand address moved while idle");
  a_w_read_narrow: assert property (avs_read && !avs_waitrequest &&
    avs_address == csd_pkg::WORKING_OFS |-> avs_readdata[31:8] == 24'h0)
    else $error("working register wider than eight bits");
endmodule

bind csd_core csd_checker chk (.ref_clk(ref_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .busy(busy), .q_phase(q_phase), .nop_substitute(nop_substitute),
  .mem_addr(mem_addr));

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, busy, nop_substitute;
  logic [1:0] q_phase;
  logic [11:0] mem_addr;
  logic [31:0] exp_q[$];
  int len_q[$];
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int blen = 0;
  int nlen = 0;
  int exp_len = 0;
  logic [11:0] ma_q[$];

  csd_core uut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .busy(busy), .q_phase(q_phase),
    .nop_substitute(nop_substitute), .mem_addr(mem_addr));

  initial forever #4 ref_clk = ~ref_clk;

  task automatic wrap_up();
    if (n_mismatch == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus master: held until waitrequest is seen low
  // ----------------------------------------------------------------
  task automatic bus(input logic rd, input logic [4:0] a,
                     input logic [31:0] d);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    do @(negedge ref_clk); while (avs_waitrequest !== 1'b0);
    @(posedge ref_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Spare edge so a following request never reassigns in this step
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b1, a, 32'h0);
  endtask

  task automatic run(input logic [15:0] ins, input int len);
    len_q.push_back(len);
    wr(csd_pkg::INSTR_OFS, 32'(ins));
    do @(negedge ref_clk); while (busy !== 1'b1);
    do @(negedge ref_clk); while (busy !== 1'b0);
    @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // Monitor: read data and instruction lengths against notes
  // ----------------------------------------------------------------
  always @(negedge ref_clk)
  begin
    if (avs_read && avs_waitrequest === 1'b0)
      chk(avs_readdata, exp_q.pop_front());
    // The no-op flag trails the sequencer by one clock, so its last
    // cycle is still seen at the edge where busy has dropped
    if (nop_substitute === 1'b1)
      nlen++;
    if (busy === 1'b1)
      blen++;
    else if (blen != 0)
    begin
      exp_len = len_q.pop_front();
      chk(32'(blen), 32'(exp_len));
      chk(32'(nlen), 32'(exp_len - 4));
      if (ma_q.size() != 0)
        chk(32'(mem_addr), 32'(ma_q.pop_front()));
      blen = 0;
      nlen = 0;
    end
  end

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial
  begin
    logic gt, a, ext, two, skip, cn;
    logic [7:0] w, v, f;
    logic [3:0] bank, lo, hi;
    logic [4:0] st;
    logic [11:0] base, addr;
    void'($urandom(32'hE3F9217A));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 48; i++)
    begin
      {two, ext, a, gt} = 4'(i);
      f = (i[5:4] == 2'h1) ? 8'h5F : (i[5:4] == 2'h2) ? 8'h60 : 8'($urandom);
      w = 8'($urandom);
      // Every third pass puts the operand equal to W
      v = (i % 3 == 0) ? w : 8'($urandom);
      bank = 4'($urandom);
      base = 12'($urandom);
      st = 5'($urandom);
      wr(csd_pkg::CTRL_OFS, 32'({two, ext}));
      wr(csd_pkg::WORKING_OFS, 32'(w));
      wr(csd_pkg::BANK_OFS, 32'(bank));
      wr(csd_pkg::OPERAND_OFS, 32'(v));
      wr(csd_pkg::INDEX_OFS, 32'(base));
      wr(csd_pkg::STATUS_OFS, 32'(st));
      skip = gt ? (v > w) : (v < w);
      addr = a ? {bank, f} : (ext && f <= 8'h5F) ? base + 12'(f) :
        (f < 8'h60) ? {4'h0, f} : {4'hF, f};
      ma_q.push_back(addr);
      run({gt ? csd_pkg::OPC_GREATER : csd_pkg::OPC_LESS, a, f},
        skip ? (two ? 12 : 8) : 4);
      rd(csd_pkg::RESULT_OFS, {17'h0, skip, !a, !a && ext && f <= 8'h5F,
        addr});
      rd(csd_pkg::STATUS_OFS, 32'(st));
    end
    // Unknown opcode, then a second one held off until the first retires
    len_q.push_back(4);
    wr(csd_pkg::INSTR_OFS, 32'h0);
    run(16'h0000, 4);
    rd(csd_pkg::RESULT_OFS, {15'h0, 3'h4, !a, !a && ext && f <= 8'h5F,
      addr});
    for (int i = 0; i < 24; i++)
    begin
      w = 8'($urandom);
      st = 5'($urandom);
      lo = (w[3:0] > 4'h9 || st[1]) ? w[3:0] + 4'h6 : w[3:0];
      hi = (w[7:4] > 4'h9 || st[0]) ? w[7:4] + 4'h6 : w[7:4];
      cn = st[0] | (w[7:4] > 4'h9);
      wr(csd_pkg::STATUS_OFS, 32'(st));
      wr(csd_pkg::WORKING_OFS, 32'(w));
      run(csd_pkg::OPC_DECIMAL_ADJUST, 4);
      rd(csd_pkg::WORKING_OFS, {24'h0, hi, lo});
      rd(csd_pkg::STATUS_OFS, {27'h0, st[4:1], cn});
    end
    rd(5'h02, 32'h0);
    wrap_up();
  end
endmodule
